/* File: design/esl_core.sv */
// Purpose: external/status latch and interrupt-pending logic of one channel
// Assumes: avalon-mm slave with waitrequest; receiver, transmitter and baud
//          generator events arrive as one-cycle pulses on CORE_CLK_I
// Notes:   modem pins pass a two flip-flop synchroniser first
//
// Summary of operation
// - enable bit one puts latch in path
// - any enabled change closes all latches, except falls of underrun and zero count
// - read shows live or captured per enable
// - reset ext/status command reopens latches
// - pending flag follows closed latches
// - master enable clear blocks pending flag
// - break/abort only in async, bit-frame
// - break sets on null, clears on one
// - abort on seven ones, cleared by zero
// - received abort forces receiver into hunt
// - both break/abort edges close latches
// - underrun clear by command never closes
// - crc load sets underrun in byte-sync and bit-frame modes
// - send abort sets; async reads one
// - cts and dcd reported, both edges close
// - odd pin transitions keep latches closed
// - zero count sets, reloads clear, live
// - zero count enable off forces zero
// - sync pin reported in async, ext-sync
// - crystal in those modes forces zero
// - hunt set by command, cleared by sync
// - bit-frame hunt entry and flag exit
// - master enable bit, per-source enables
// - disabled source never raises interrupt
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "esl_params.svh"
module esl_core
  import esl_pkg::*;
(
  input  wire logic                 CORE_CLK_I,
  input  wire logic                 SYS_RST_I,
  // avalon-mm slave
  input  wire logic [`ESL_ADR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                 AVS_READ_I,
  input  wire logic                 AVS_WRITE_I,
  input  wire logic [31:0]          AVS_WRITEDATA_I,
  output logic      [31:0]          AVS_READDATA_O,
  output logic                      AVS_WAITREQUEST_O,
  // modem pins
  input  wire logic                 CLEAR_TO_SEND_N_I,
  input  wire logic                 CARRIER_DETECT_I,
  input  wire logic                 CHAR_SYNC_I,
  // receiver events
  input  wire logic                 RX_BIT_VALID_I,
  input  wire logic                 RX_BIT_I,
  input  wire logic                 RX_NULL_FERR_I,
  input  wire logic                 RX_FLAG_I,
  input  wire logic                 RX_SYNC_MATCH_I,
  // transmitter and baud generator events
  input  wire logic                 TX_CRC_LOAD_I,
  input  wire logic                 BRG_ZERO_I,
  input  wire logic                 BRG_RELOAD_I,
  // outputs
  output logic                      RX_NULL_PUSH_O,
  output logic                      TX_SEND_ABORT_O,
  output logic                      RX_HUNT_O,
  output logic                      EXT_STATUS_IP_O
);

  // ---------------- register state ----------------
  esl_src_t   enable_q;
  logic       master_en_q;
  logic       rx_en_q;
  logic [1:0] mode_q;
  logic       xtal_q;
  logic       ack_q;
  logic       wr_go;
  logic [2:0] cmd_w;
  logic       cmd_rst_es;
  logic       cmd_abort;
  logic       cmd_rst_eom;
  logic       cmd_hunt;
  logic       rx_en_rise;

  // ---------------- source state ----------------
  logic [2:0] pin_s;
  logic       brk_abt;
  logic       eom_q;
  logic       zc_q;
  logic       hunt_q;
  logic       sync_forced;
  esl_src_t   live_w;
  esl_src_t   prev_q;
  esl_src_t   chg_w;
  esl_src_t   latched_q;
  esl_src_t   status_w;
  esl_lat_t   lat_q;
  esl_lat_t   lat_d;
  logic       trig_w;
  logic       odd_w;

  function automatic logic is_sync_mode(input logic [1:0] m);
    is_sync_mode = (m == `ESL_MODE_BYTE) || (m == `ESL_MODE_BITF);
  endfunction

  function automatic logic [31:0] zext6(input esl_src_t v);
    zext6 = {26'h0, v};
  endfunction

  // ---------------- avalon slave ----------------
  // one wait state: read data loads on the first edge, write side effects land on the second
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign wr_go             = AVS_WRITE_I & ack_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
    end
  end

  // read data loads on the first edge and stands until the next read
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h0;
    end else if (AVS_READ_I && !ack_q) begin
      case (AVS_ADDRESS_I)
        `ESL_ADR_STATUS: AVS_READDATA_O <= zext6(status_w);
        `ESL_ADR_ENABLE: AVS_READDATA_O <= zext6(enable_q);
        `ESL_ADR_INTCTL: AVS_READDATA_O <= {31'h0, master_en_q};
        `ESL_ADR_RXCTL:  AVS_READDATA_O <= {30'h0, hunt_q, rx_en_q};
        `ESL_ADR_MODE:   AVS_READDATA_O <= {29'h0, xtal_q, mode_q};
        `ESL_ADR_IPSTAT: AVS_READDATA_O <= {30'h0, lat_q == LAT_CLOSED,
                                            EXT_STATUS_IP_O};
        default:         AVS_READDATA_O <= 32'h0;
      endcase
    end
  end

  assign cmd_w       = AVS_WRITEDATA_I[2:0];
  assign cmd_rst_es  = wr_go && AVS_ADDRESS_I == `ESL_ADR_CMD && cmd_w == `ESL_CMD_RST_ES;
  assign cmd_abort   = wr_go && AVS_ADDRESS_I == `ESL_ADR_CMD && cmd_w == `ESL_CMD_ABORT;
  assign cmd_rst_eom = wr_go && AVS_ADDRESS_I == `ESL_ADR_CMD && cmd_w == `ESL_CMD_RST_EOM;
  assign cmd_hunt    = wr_go && AVS_ADDRESS_I == `ESL_ADR_RXCTL
                       && AVS_WRITEDATA_I[`ESL_B_HUNT];
  assign rx_en_rise  = wr_go && AVS_ADDRESS_I == `ESL_ADR_RXCTL
                       && AVS_WRITEDATA_I[`ESL_B_RX_EN] && !rx_en_q;

  // mode and enable registers
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      enable_q    <= `ESL_ENABLE_RST;
      master_en_q <= 1'b0;
      rx_en_q     <= 1'b0;
      {xtal_q, mode_q} <= `ESL_MODE_RST;
    end else if (wr_go) begin
      case (AVS_ADDRESS_I)
        `ESL_ADR_ENABLE: enable_q    <= AVS_WRITEDATA_I[5:0];
        `ESL_ADR_INTCTL: master_en_q <= AVS_WRITEDATA_I[`ESL_B_MASTER_EN];
        `ESL_ADR_RXCTL:  rx_en_q     <= AVS_WRITEDATA_I[`ESL_B_RX_EN];
        `ESL_ADR_MODE:   {xtal_q, mode_q} <= AVS_WRITEDATA_I[2:0];
        default: begin
        end
      endcase
    end
  end

  assign TX_SEND_ABORT_O = cmd_abort;

  // ---------------- pins and receiver ----------------
  esl_sync2 #(
    .W (3)
  ) u_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (SYS_RST_I),
    .d_i   ({~CLEAR_TO_SEND_N_I, CARRIER_DETECT_I, CHAR_SYNC_I}),
    .q_o   (pin_s)
  );

  esl_rxbrk u_brk (
    .clk_i       (CORE_CLK_I),
    .rst_i       (SYS_RST_I),
    .mode_i      (mode_q),
    .bit_vld_i   (RX_BIT_VALID_I),
    .bit_i       (RX_BIT_I),
    .null_ferr_i (RX_NULL_FERR_I),
    .brk_abt_o   (brk_abt),
    .null_push_o (RX_NULL_PUSH_O)
  );

  // ---------------- transmit underrun/end_of_message ----------------
  // a set in the same cycle as the reset command wins
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      eom_q <= 1'b0;
    end else if (cmd_abort) begin
      eom_q <= 1'b1;
    end else if (TX_CRC_LOAD_I && is_sync_mode(mode_q)) begin
      eom_q <= 1'b1;
    end else if (cmd_rst_eom) begin
      eom_q <= 1'b0;
    end
  end

  // ---------------- zero_count ----------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      zc_q <= 1'b0;
    end else if (BRG_ZERO_I) begin
      zc_q <= 1'b1;
    end else if (BRG_RELOAD_I) begin
      zc_q <= 1'b0;
    end
  end

  // ---------------- hunt ----------------
  // bit-frame enters on command, abort or receiver enable and leaves on a
  // flag; byte sync leaves on a match; other modes only ever set it
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      hunt_q <= 1'b0;
    end else if (mode_q == `ESL_MODE_BITF) begin
      if (cmd_hunt || rx_en_rise || (brk_abt && !prev_q.break_abort)) begin
        hunt_q <= 1'b1;
      end else if (RX_FLAG_I) begin
        hunt_q <= 1'b0;
      end
    end else if (mode_q == `ESL_MODE_BYTE) begin
      if (cmd_hunt) begin
        hunt_q <= 1'b1;
      end else if (RX_SYNC_MATCH_I) begin
        hunt_q <= 1'b0;
      end
    end else if (cmd_hunt) begin
      hunt_q <= 1'b1;
    end
  end

  assign RX_HUNT_O = hunt_q;

  // ---------------- live source vector ----------------
  assign sync_forced = xtal_q && (mode_q == `ESL_MODE_ASYNC
                                  || mode_q == `ESL_MODE_EXTSYNC);

  always_comb begin
    live_w.break_abort = brk_abt;
    live_w.tx_eom      = (mode_q == `ESL_MODE_ASYNC) ? 1'b1 : eom_q;
    live_w.cts         = pin_s[2];
    live_w.dcd         = pin_s[1];
    if (sync_forced) begin
      live_w.sync_hunt = 1'b0;
    end else if (is_sync_mode(mode_q)) begin
      live_w.sync_hunt = hunt_q;
    end else begin
      live_w.sync_hunt = pin_s[0];
    end
    live_w.zero_count  = zc_q & enable_q.zero_count;
  end

  // previous-cycle live vector; every edge test below compares against it
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      prev_q <= '0;
    end else begin
      prev_q <= live_w;
    end
  end

  // ---------------- change detection ----------------
  // one-way sources only count a rise; sync is masked while forced
  always_comb begin
    chg_w             = live_w ^ prev_q;
    chg_w.break_abort = live_w.break_abort ^ prev_q.break_abort;
    chg_w.tx_eom      = live_w.tx_eom & ~prev_q.tx_eom;
    chg_w.zero_count  = live_w.zero_count & ~prev_q.zero_count;
    chg_w.sync_hunt   = (live_w.sync_hunt ^ prev_q.sync_hunt) & ~sync_forced;
  end

  // only enabled sources can close the group
  assign trig_w = |(chg_w & enable_q);

  // pin that ended on the other level than captured: odd transitions
  assign odd_w = |(({latched_q.cts, latched_q.dcd, latched_q.sync_hunt}
                    ^ {live_w.cts, live_w.dcd, live_w.sync_hunt})
                   & {enable_q.cts, enable_q.dcd, enable_q.sync_hunt});

  // ---------------- latch group state ----------------
  always_comb begin
    case (lat_q)
      LAT_OPEN: begin
        lat_d = trig_w ? LAT_CLOSED : LAT_OPEN;
      end
      LAT_CLOSED: begin
        if (cmd_rst_es) begin
          lat_d = (odd_w || trig_w) ? LAT_CLOSED : LAT_OPEN;
        end else begin
          lat_d = LAT_CLOSED;
        end
      end
      default: begin
        lat_d = LAT_OPEN;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      lat_q <= LAT_OPEN;
    end else begin
      lat_q <= lat_d;
    end
  end

  // capture follows the live value while open, freezes while closed;
  // a reset command re-takes the current values, so a group that stays
  // closed on an odd pin count shows the new level, not the old one
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      latched_q <= '0;
    end else if (lat_q == LAT_OPEN || cmd_rst_es) begin
      latched_q <= live_w;
    end
  end

  // ---------------- readable status ----------------
  // zero_count bypasses the latch and always reads live
  always_comb begin
    status_w = live_w;
    if (lat_q == LAT_CLOSED) begin
      status_w = (latched_q & enable_q) | (live_w & ~enable_q);
    end
    status_w.zero_count = live_w.zero_count;
  end

  // ---------------- interrupt pending ----------------
  // pending follows the next group state, so it moves with the latches
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      EXT_STATUS_IP_O <= 1'b0;
    end else begin
      EXT_STATUS_IP_O <= (lat_d == LAT_CLOSED) && master_en_q;
    end
  end

endmodule

/* File: design/esl_params.svh */
// Purpose: register map, field codes and reset values of the ext/status latch block
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes:   included by bare name
`ifndef ESL_PARAMS_SVH
`define ESL_PARAMS_SVH

`define ESL_ADR_W        5
`define ESL_ADR_STATUS   5'h00
`define ESL_ADR_ENABLE   5'h04
`define ESL_ADR_CMD      5'h08
`define ESL_ADR_INTCTL   5'h0c
`define ESL_ADR_RXCTL    5'h10
`define ESL_ADR_MODE     5'h14
`define ESL_ADR_IPSTAT   5'h18

`define ESL_CMD_RST_ES   3'h2
`define ESL_CMD_ABORT    3'h3
`define ESL_CMD_RST_EOM  3'h6

`define ESL_MODE_ASYNC   2'h0
`define ESL_MODE_BYTE    2'h1
`define ESL_MODE_EXTSYNC 2'h2
`define ESL_MODE_BITF    2'h3

`define ESL_B_MASTER_EN  0
`define ESL_B_RX_EN      0
`define ESL_B_HUNT       1
`define ESL_B_XTAL       2
`define ESL_B_IP         0
`define ESL_B_CLOSED     1

`define ESL_ENABLE_RST   6'h00
`define ESL_MODE_RST     3'h0
`define ESL_ABORT_ONES   3'h7

`endif

/* File: design/esl_pkg.sv */
// Purpose: shared types of the ext/status latch block
// Assumes: esl_params.svh holds the numbers
// Notes:   source vector order fixes the status bit positions
package esl_pkg;

  typedef struct packed {
    logic break_abort;
    logic tx_eom;
    logic cts;
    logic dcd;
    logic sync_hunt;
    logic zero_count;
  } esl_src_t;

  typedef enum logic [1:0] {
    LAT_OPEN   = 2'b01,
    LAT_CLOSED = 2'b10
  } esl_lat_t;

endpackage

/* File: design/esl_rxbrk.sv */
// Purpose: break detect (async) and abort detect (bit-oriented frames)
// Assumes: receiver supplies bit strobes and a null-with-framing-error pulse
// Notes:   status reads 0 in other synchronous modes
`timescale 1ns/100ps
`include "esl_params.svh"
module esl_rxbrk
  import esl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       bit_vld_i,
  input  wire logic       bit_i,
  input  wire logic       null_ferr_i,
  output logic            brk_abt_o,
  output logic            null_push_o
);
  logic       async_w;
  logic       bitf_w;
  logic [2:0] ones_q;
  logic       flag_q;

  assign async_w = (mode_i == `ESL_MODE_ASYNC);
  assign bitf_w  = (mode_i == `ESL_MODE_BITF);

  // count contiguous ones, saturating at the abort length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ones_q <= 3'h0;
    end else if (bit_vld_i) begin
      if (!bit_i) begin
        ones_q <= 3'h0;
      end else if (ones_q != `ESL_ABORT_ONES) begin
        ones_q <= ones_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q      <= 1'b0;
      null_push_o <= 1'b0;
    end else begin
      null_push_o <= 1'b0;
      if (async_w) begin
        if (null_ferr_i) begin
          flag_q <= 1'b1;
        end else if (bit_vld_i && bit_i && flag_q) begin
          flag_q      <= 1'b0;
          null_push_o <= 1'b1;
        end
      end else if (bitf_w) begin
        if (bit_vld_i && bit_i && ones_q == `ESL_ABORT_ONES - 3'h1) begin
          flag_q <= 1'b1;
        end else if (bit_vld_i && !bit_i) begin
          flag_q <= 1'b0;
        end
      end else begin
        flag_q <= 1'b0;
      end
    end
  end

  assign brk_abt_o = flag_q & (async_w | bitf_w);
endmodule

/* File: design/esl_sync2.sv */
// Purpose: two flip-flop synchroniser for the modem pins
// Assumes: pins are asynchronous to CORE_CLK_I
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module esl_sync2 #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      q_o  <= s1_q;
    end
  end
endmodule

/* File: sim/esl_chk_sva.sv */
// Purpose: port-level assertions of the ext/status latch block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to esl_core below its endmodule
`timescale 1ns/100ps
`include "esl_params.svh"
module esl_chk (
  input  wire logic                  CORE_CLK_I,
  input  wire logic                  SYS_RST_I,
  input  wire logic [`ESL_ADR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [31:0]           AVS_WRITEDATA_I,
  input  wire logic                  AVS_WAITREQUEST_O,
  input  wire logic                  RX_BIT_VALID_I,
  input  wire logic                  RX_BIT_I,
  input  wire logic                  RX_FLAG_I,
  input  wire logic                  RX_SYNC_MATCH_I,
  input  wire logic                  RX_NULL_PUSH_O,
  input  wire logic                  TX_SEND_ABORT_O,
  input  wire logic                  RX_HUNT_O,
  input  wire logic                  EXT_STATUS_IP_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire logic acc_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  wire logic cmd_es = AVS_ADDRESS_I == `ESL_ADR_CMD && AVS_WRITEDATA_I[2:0] == `ESL_CMD_RST_ES;

  a_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=>
    !AVS_WAITREQUEST_O) else $error("waitrequest held past one cycle");
  a_rst_ip_low: assert property (disable iff (1'b0) SYS_RST_I |=> !EXT_STATUS_IP_O)
    else $error("pending flag set after reset");
  a_ip_drop_cause: assert property ($fell(EXT_STATUS_IP_O) |-> $past(SYS_RST_I) ||
    $past(acc_wr && (cmd_es || AVS_ADDRESS_I == `ESL_ADR_INTCTL)))
    else $error("pending flag dropped without command");
  a_abort_cause: assert property (TX_SEND_ABORT_O |-> AVS_WRITE_I &&
    AVS_ADDRESS_I == `ESL_ADR_CMD && AVS_WRITEDATA_I[2:0] == `ESL_CMD_ABORT)
    else $error("send abort without command");
  a_abort_pulse: assert property (TX_SEND_ABORT_O |=> !TX_SEND_ABORT_O)
    else $error("send abort longer than one cycle");
  a_push_cause: assert property (RX_NULL_PUSH_O |-> $past(RX_BIT_VALID_I && RX_BIT_I) ||
    $past(RX_BIT_VALID_I && RX_BIT_I, 2)) else $error("null push without a one bit");
  a_push_pulse: assert property (RX_NULL_PUSH_O ##1 !RX_NULL_PUSH_O or !RX_NULL_PUSH_O)
    else $error("null push longer than one cycle");
  a_hunt_cmd: assert property (acc_wr && AVS_ADDRESS_I == `ESL_ADR_RXCTL &&
    AVS_WRITEDATA_I[1] |=> RX_HUNT_O) else $error("hunt not entered on command");
  a_hunt_exit: assert property ($fell(RX_HUNT_O) |->
    $past(RX_SYNC_MATCH_I || RX_FLAG_I || SYS_RST_I)) else $error("hunt left without cause");

  c_ip_rise: cover property ($rose(EXT_STATUS_IP_O));
  c_push: cover property (RX_NULL_PUSH_O);
  c_abort: cover property (TX_SEND_ABORT_O);
  c_hunt_exit: cover property ($fell(RX_HUNT_O));
endmodule

bind esl_core esl_chk i_esl_chk (.CORE_CLK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_WAITREQUEST_O, .RX_BIT_VALID_I, .RX_BIT_I,
  .RX_FLAG_I, .RX_SYNC_MATCH_I, .RX_NULL_PUSH_O, .TX_SEND_ABORT_O, .RX_HUNT_O,
  .EXT_STATUS_IP_O);

/* File: sim/esl_host.sv */
// Purpose: host processor model driving the avalon-mm register port
// Assumes: slave answers through waitrequest
// Notes:   request held until waitrequest is seen low at a rising edge
`timescale 1ns/100ps
`include "esl_params.svh"
module esl_host (
  input  wire logic                  clk_i,
  input  wire logic                  waitrequest_i,
  input  wire logic [31:0]           readdata_i,
  output logic      [`ESL_ADR_W-1:0] address_o = '0,
  output logic                       read_o = 1'b0,
  output logic                       write_o = 1'b0,
  output logic      [31:0]           writedata_o = '0
);
  task automatic acc(input logic wr, input logic [`ESL_ADR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int   n;
    logic ws;
    n = 0;
    @(posedge clk_i);
    address_o   <= a;
    writedata_o <= d;
    read_o      <= !wr;
    write_o     <= wr;
    // waitrequest and read data are taken as they stand at the rising edge
    do begin
      @(posedge clk_i);
      ws = waitrequest_i;
      q  = readdata_i;
      n++;
    end while (ws !== 1'b0 && n < 20);
    read_o  <= 1'b0;
    write_o <= 1'b0;
    if (ws !== 1'b0) begin
      tb.errors++;
      tb.conclude();
    end
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: self-checking bench of the ext/status latch block
// Assumes: esl_host drives the register port
// Notes:   pins settle 7 cycles after each toggle
`timescale 1ns/100ps
`include "esl_params.svh"
module tb;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [`ESL_ADR_W-1:0] adr;
  logic                  rd;
  logic                  wr;
  logic [31:0]           wd;
  logic [31:0]           rdat;
  logic                  wreq;
  logic [2:0]            pin = 3'b001;
  logic                  bv = 1'b0;
  logic                  bt = 1'b0;
  logic [5:0]            ev = 6'h00;
  logic                  push;
  logic                  sab;
  logic                  hunt;
  logic                  ip;
  int                    errors = 0;
  int                    checks = 0;
  int                    npush = 0;
  int                    nab = 0;
  int                    k;

  always #2.5 clk = !clk;
  always @(posedge clk) begin
    if (push) npush++;
    if (sab) nab++;
  end

  esl_host i_esl_host (.clk_i(clk), .waitrequest_i(wreq), .readdata_i(rdat), .address_o(adr),
    .read_o(rd), .write_o(wr), .writedata_o(wd));
  esl_core i_esl_core (.CORE_CLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wreq),
    .CLEAR_TO_SEND_N_I(pin[0]), .CARRIER_DETECT_I(pin[1]), .CHAR_SYNC_I(pin[2]),
    .RX_BIT_VALID_I(bv), .RX_BIT_I(bt), .RX_NULL_FERR_I(ev[5]), .RX_FLAG_I(ev[4]),
    .RX_SYNC_MATCH_I(ev[3]), .TX_CRC_LOAD_I(ev[2]), .BRG_ZERO_I(ev[0]),
    .BRG_RELOAD_I(ev[1]), .RX_NULL_PUSH_O(push), .TX_SEND_ABORT_O(sab),
    .RX_HUNT_O(hunt), .EXT_STATUS_IP_O(ip));

  task automatic conclude;
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // status with live dcd folded in
  function automatic logic [31:0] st(input logic [5:0] b);
    return {26'h0, b | {3'b000, pin[1], 2'b00}};
  endfunction
  task automatic w(input logic [`ESL_ADR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_esl_host.acc(1'b1, a, d, q);
  endtask
  task automatic r(input logic [`ESL_ADR_W-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_esl_host.acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic ipc(input logic e);
    repeat (2) @(negedge clk);
    chk(32'(ip), 32'(e));
  endtask
  task automatic tog(input int p);
    @(posedge clk);
    pin[p] <= !pin[p];
    repeat (7) @(posedge clk);
  endtask
  task automatic pulse(input int p);
    @(posedge clk);
    ev[p] <= 1'b1;
    @(posedge clk);
    ev[p] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic bits(input int n, input logic v);
    repeat (n) begin
      @(posedge clk);
      bv <= 1'b1;
      bt <= v;
    end
    @(posedge clk);
    bv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic reopen;
    w(`ESL_ADR_ENABLE, 32'h0);
    w(`ESL_ADR_CMD, {24'h0, 5'($urandom), `ESL_CMD_RST_ES});
  endtask

  initial begin
    void'($urandom(32'h8ed2));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    r(`ESL_ADR_STATUS, 32'h10);
    r(`ESL_ADR_IPSTAT, 32'h0);
    r(5'h1c, 32'h0);
    w(`ESL_ADR_ENABLE, 32'h04);
    w(`ESL_ADR_INTCTL, 32'h1);
    r(`ESL_ADR_INTCTL, 32'h1);
    for (int i = 0; i < 6; i++) begin
      k = 1 + $urandom % 4;
      r(`ESL_ADR_STATUS, st(6'h10));
      repeat (k) tog(1);
      chk(32'(ip), 32'h1);
      r(`ESL_ADR_STATUS, st(6'h10) ^ 32'(k % 2 == 0) << 2);
      w(`ESL_ADR_CMD, 32'h2);
      ipc(k % 2 == 0);
      reopen();
      ipc(1'b0);
      w(`ESL_ADR_ENABLE, 32'h04);
    end
    w(`ESL_ADR_INTCTL, 32'h0);
    tog(1);
    ipc(1'b0);
    r(`ESL_ADR_IPSTAT, 32'h2);
    w(`ESL_ADR_CMD, 32'h2);
    r(`ESL_ADR_IPSTAT, 32'h0);
    w(`ESL_ADR_INTCTL, 32'h1);
    tog(0);
    ipc(1'b0);
    r(`ESL_ADR_STATUS, st(6'h18));
    tog(0);
    w(`ESL_ADR_MODE, 32'h1);
    w(`ESL_ADR_CMD, 32'h6);
    r(`ESL_ADR_STATUS, st(6'h00));
    w(`ESL_ADR_ENABLE, 32'h10);
    pulse(2);
    ipc(1'b1);
    w(`ESL_ADR_CMD, 32'h2);
    w(`ESL_ADR_CMD, 32'h6);
    ipc(1'b0);
    w(`ESL_ADR_CMD, 32'h3);
    ipc(1'b1);
    w(`ESL_ADR_ENABLE, 32'h1);
    w(`ESL_ADR_CMD, 32'h2);
    pulse(0);
    ipc(1'b1);
    r(`ESL_ADR_STATUS, st(6'h11));
    pulse(1);
    r(`ESL_ADR_STATUS, st(6'h10));
    w(`ESL_ADR_CMD, 32'h2);
    ipc(1'b0);
    w(`ESL_ADR_ENABLE, 32'h0);
    pulse(0);
    r(`ESL_ADR_STATUS, st(6'h10));
    w(`ESL_ADR_MODE, 32'h3);
    w(`ESL_ADR_RXCTL, 32'h3);
    pulse(4);
    chk(32'(hunt), 32'h0);
    w(`ESL_ADR_ENABLE, 32'h22);
    bits(7, 1'b1);
    chk(32'(hunt), 32'h1);
    ipc(1'b1);
    w(`ESL_ADR_CMD, 32'h2);
    r(`ESL_ADR_STATUS, st(6'h32));
    bits(1, 1'b0);
    ipc(1'b1);
    pulse(4);
    chk(32'(hunt), 32'h0);
    reopen();
    w(`ESL_ADR_MODE, 32'h0);
    pulse(5);
    bits(3, 1'b0);
    r(`ESL_ADR_STATUS, st(6'h30));
    bits(1, 1'b1);
    r(`ESL_ADR_STATUS, st(6'h10));
    chk(npush, 1);
    w(`ESL_ADR_MODE, 32'h1);
    w(`ESL_ADR_ENABLE, 32'h2);
    w(`ESL_ADR_RXCTL, 32'h3);
    ipc(1'b1);
    w(`ESL_ADR_CMD, 32'h2);
    pulse(3);
    chk(32'(hunt), 32'h0);
    ipc(1'b1);
    reopen();
    w(`ESL_ADR_MODE, 32'h0);
    w(`ESL_ADR_ENABLE, 32'h2);
    tog(2);
    ipc(1'b1);
    r(`ESL_ADR_STATUS, st(6'h12));
    tog(2);
    reopen();
    w(`ESL_ADR_MODE, 32'h4);
    w(`ESL_ADR_ENABLE, 32'h2);
    tog(2);
    ipc(1'b0);
    r(`ESL_ADR_STATUS, st(6'h10));
    reopen();
    w(`ESL_ADR_MODE, 32'h2);
    w(`ESL_ADR_ENABLE, 32'h2);
    tog(2);
    ipc(1'b1);
    r(`ESL_ADR_STATUS, st(6'h10));
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    r(`ESL_ADR_IPSTAT, 32'h0);
    r(`ESL_ADR_STATUS, st(6'h10));
    w(`ESL_ADR_MODE, 32'h6);
    w(`ESL_ADR_ENABLE, 32'h2);
    w(`ESL_ADR_INTCTL, 32'h1);
    tog(2);
    ipc(1'b0);
    r(`ESL_ADR_STATUS, st(6'h00));
    chk(nab, 1);
    conclude();
  end
endmodule
